//--- hw/stp_pkg.sv
package stp_pkg;
  // Register word indices; byte address is four times the index
  localparam logic [9:0] IDX_CTRL = 10'h200;
  localparam logic [9:0] IDX_STAT = 10'h201;
  localparam logic [9:0] IDX_PAT = 10'h205;
  localparam logic [9:0] IDX_ID = 10'h206;
  localparam logic [9:0] IDX_EOF = 10'h207;
  // Control register fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_ENC_BIT = 1;
  // Reset values
  localparam logic [1:0] RST_CTRL = 2'h0;
  localparam logic [4:0] RST_PAT = 5'h00;
  localparam logic [7:0] RST_ID = 8'h00;
  localparam logic [1:0] RST_EOF = 2'h0;
  // Pattern select codes
  localparam logic [4:0] PAT_NORMAL = 5'h00;
  localparam logic [4:0] PAT_PRBS7 = 5'h01;
  localparam logic [4:0] PAT_PRBS15 = 5'h02;
  localparam logic [4:0] PAT_PRBS23 = 5'h03;
  localparam logic [4:0] PAT_RAMP = 5'h04;
  localparam logic [4:0] PAT_TRANSPORT = 5'h05;
  localparam logic [4:0] PAT_D21_5 = 5'h06;
  localparam logic [4:0] PAT_K28_5 = 5'h07;
  localparam logic [4:0] PAT_ILA = 5'h08;
  localparam logic [4:0] PAT_RPAT = 5'h09;
  localparam logic [4:0] PAT_LOW = 5'h0A;
  localparam logic [4:0] PAT_HIGH = 5'h0B;
  localparam logic [4:0] PAT_PRBS9 = 5'h0D;
  localparam logic [4:0] PAT_PRBS31 = 5'h0E;
  localparam logic [4:0] PAT_CLOCK = 5'h0F;
  localparam logic [4:0] PAT_K28_7 = 5'h10;
  // End-of-frame select codes
  localparam logic [1:0] EOF_K28_7 = 2'h0;
  localparam logic [1:0] EOF_K28_1 = 2'h1;
  localparam logic [1:0] EOF_K28_5 = 2'h2;
  // 8b/10b characters, unencoded
  localparam logic [7:0] CH_K28_0 = 8'h1C;
  localparam logic [7:0] CH_K28_1 = 8'h3C;
  localparam logic [7:0] CH_K28_3 = 8'h7C;
  localparam logic [7:0] CH_K28_4 = 8'h9C;
  localparam logic [7:0] CH_K28_5 = 8'hBC;
  localparam logic [7:0] CH_K28_7 = 8'hFC;
  localparam logic [7:0] CH_D21_5 = 8'hB5;
  // Raw line words
  localparam logic [15:0] WORD_LOW = 16'h0000;
  localparam logic [15:0] WORD_HIGH = 16'hFFFF;
  localparam logic [15:0] WORD_CLOCK = 16'h00FF;
  localparam logic [30:0] PRBS_SEED = 31'h7FFFFFFF;
  // Sequence lengths
  localparam logic [2:0] ILA_LAST_WORD = 3'h7;
  localparam logic [1:0] ILA_ID_MF = 2'h1;
  localparam logic [2:0] RPAT_LAST = 3'h5;
  localparam logic [7:0] RAMP_STEP = 8'h02;
  // Data path
  localparam int WORD_W = 16;
  localparam int FIFO_DEPTH = 8;
  typedef enum logic [1:0] {BUS_IDLE = 2'b01, BUS_ACK = 2'b10} stp_bus_t;
endpackage : stp_pkg

//--- hw/stp_fifo_if.sv
`timescale 1ns/1ps
interface stp_fifo_if #(parameter int W = 16);
  logic push_valid;
  logic push_ready;
  logic [W-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [W-1:0] pop_data;
  modport buf_side (input push_valid, push_data, pop_ready,
    output push_ready, pop_valid, pop_data);
  modport user (output push_valid, push_data, pop_ready, input push_ready, pop_valid, pop_data);
endinterface : stp_fifo_if

//--- hw/stp_fifo.sv
`timescale 1ns/1ps
module stp_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  input wire logic ref_clk, // Clock
  input wire logic rst, // Synchronous reset
  stp_fifo_if.buf_side f // Push and pop sides
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);
  logic [W-1:0] mem_q [D];
  logic [W-1:0] mem_d [D];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic push, pop;

  assign f.push_ready = (cnt_q != CW'(D));
  assign f.pop_valid = (cnt_q != '0);
  assign f.pop_data = mem_q[rp_q];

  always_comb
  begin
    push = f.push_valid && f.push_ready;
    pop = f.pop_valid && f.pop_ready;
    mem_d = mem_q;
    if (push)
      mem_d[wp_q] = f.push_data;
    wp_d = push ? ((wp_q == AW'(D - 1)) ? '0 : AW'(wp_q + 1'b1)) : wp_q;
    rp_d = pop ? ((rp_q == AW'(D - 1)) ? '0 : AW'(rp_q + 1'b1)) : rp_q;
    cnt_d = CW'(cnt_q + CW'(push) - CW'(pop));
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    mem_q <= mem_d;
  end

  a_fifo_count_bound: assert property (@(posedge ref_clk) disable iff (rst) cnt_q <= CW'(D))
    else $error("fifo count above depth");
endmodule : stp_fifo

//--- hw/stp_gen.sv
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ps
// Notes on behaviour
// - Pattern code 0 sends lane data; 1, 2, 3 send PRBS7, PRBS15, PRBS23.
// - Code 13 sends PRBS9 and code 14 sends PRBS31.
// - Code 4 sends a ramp, code 5 the transport layer test pattern.
// - Codes 6, 7, 16 repeat D21.5, K28.5 and K28.7 on the lane.
// - Code 8 repeats the lane alignment sequence, code 9 the modified RPAT.
// - Code 10 holds the line low, code 11 holds it high.
// - Code 15 sends eight zeros then eight ones, repeating.
// - The identifier goes out in the second multiframe of the alignment sequence.
// - The first link sends the identifier, the second link sends it plus one.
// - Identifier bit 0 is forced to zero on write and read.
// - Frame-end select: 0 K28.7, 1 K28.1, 2 K28.5, 3 reserved.
// - The frame-end character replaces the last octet only when it repeats.
// - Frame-end substitution happens only in 8b/10b, never in 64b/66b.
module stp_gen (
  input wire logic ref_clk, // 250 MHz clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic [11:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  input wire logic smp_valid, // Sample word valid
  input wire logic [15:0] smp_data, // Sample word, two octets
  output logic smp_ready, // Buffer has room
  input wire logic link_b, // High on the second link
  input wire logic tx_ready, // Serializer takes a word
  output logic tx_valid, // Word on tx_data is meaningful
  output logic [15:0] tx_data, // Lane word, high octet first
  output logic [1:0] tx_k, // Control flag per octet
  output logic tx_raw // Word bypasses the line encoder
);
  stp_pkg::stp_bus_t bus_q, bus_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] ctrl_q, ctrl_d;
  logic [4:0] pat_q, pat_d;
  logic [7:0] ila_id_q, ila_id_d;
  logic [1:0] eof_sel_q, eof_sel_d;
  logic [7:0] rd_mux;
  logic link_enable, enc64;
  logic [7:0] tx_id;
  logic [30:0] prbs_q, prbs_d;
  logic [7:0] cnt_q, cnt_d;
  logic [1:0] mf_q, mf_d;
  logic [7:0] prev_q, prev_d;
  logic tx_valid_q, tx_valid_d;
  logic [15:0] tx_data_q, tx_data_d;
  logic [1:0] tx_k_q, tx_k_d;
  logic tx_raw_q, tx_raw_d;
  logic [46:0] pr;
  logic [9:0] plt;
  logic [15:0] w;
  logic [1:0] k;
  logic raw, ok;

  stp_fifo_if #(.W(stp_pkg::WORD_W)) fq ();

  function automatic logic [9:0] word_idx(input logic [11:0] a);
    return a[11:2];
  endfunction : word_idx

  // Shifts sixteen bits out of a Fibonacci LFSR of the given length and tap
  function automatic logic [46:0] prbs16(input logic [30:0] s, input logic [4:0] len,
                                         input logic [4:0] tap);
    logic [30:0] st;
    logic [15:0] o;
    logic fb;
    st = s;
    o = '0;
    fb = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      fb = st[len - 5'h01] ^ st[tap - 5'h01];
      st = {st[29:0], fb};
      o[i] = fb;
    end
    return {o, st};
  endfunction : prbs16

  function automatic logic [9:0] prbs_poly(input logic [4:0] p);
    unique case (p)
      stp_pkg::PAT_PRBS7: return {5'h07, 5'h06};
      stp_pkg::PAT_PRBS9: return {5'h09, 5'h05};
      stp_pkg::PAT_PRBS15: return {5'h0F, 5'h0E};
      stp_pkg::PAT_PRBS23: return {5'h17, 5'h12};
      default: return {5'h1F, 5'h1C};
    endcase
  endfunction : prbs_poly

  function automatic logic [7:0] eof_char(input logic [1:0] sel);
    unique case (sel)
      stp_pkg::EOF_K28_1: return stp_pkg::CH_K28_1;
      stp_pkg::EOF_K28_5: return stp_pkg::CH_K28_5;
      default: return stp_pkg::CH_K28_7;
    endcase
  endfunction : eof_char

  function automatic logic [15:0] rpat_word(input logic [2:0] i);
    unique case (i)
      3'h0: return 16'hBED7;
      3'h1: return 16'h2347;
      3'h2: return 16'h6B8F;
      3'h3: return 16'hB314;
      3'h4: return 16'h5EFB;
      default: return 16'h3559;
    endcase
  endfunction : rpat_word

  assign link_enable = ctrl_q[stp_pkg::CTRL_EN_BIT];
  assign enc64 = ctrl_q[stp_pkg::CTRL_ENC_BIT];
  assign tx_id = 8'(ila_id_q + {7'h00, link_b});

  assign fq.push_valid = smp_valid;
  assign fq.push_data = smp_data;
  assign smp_ready = fq.push_ready;
  assign fq.pop_ready = link_enable && tx_ready && (pat_q == stp_pkg::PAT_NORMAL);

  stp_fifo #(.W(stp_pkg::WORD_W), .D(stp_pkg::FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .f(fq.buf_side)
  );

  assign avs_waitrequest = (bus_q != stp_pkg::BUS_ACK);
  assign avs_readdata = rdata_q;
  assign tx_valid = tx_valid_q;
  assign tx_data = tx_data_q;
  assign tx_k = tx_k_q;
  assign tx_raw = tx_raw_q;

  always_comb
  begin
    case (word_idx(avs_address))
      stp_pkg::IDX_CTRL: rd_mux = {6'h00, ctrl_q};
      stp_pkg::IDX_STAT: rd_mux = {4'h0, fq.pop_valid, fq.push_ready, tx_valid_q, link_enable};
      stp_pkg::IDX_PAT: rd_mux = {3'h0, pat_q};
      stp_pkg::IDX_ID: rd_mux = {ila_id_q[7:1], 1'b0};
      stp_pkg::IDX_EOF: rd_mux = {6'h00, eof_sel_q};
      default: rd_mux = 8'h00;
    endcase
  end

  always_comb
  begin
    bus_d = bus_q;
    rdata_d = rdata_q;
    ctrl_d = ctrl_q;
    pat_d = pat_q;
    ila_id_d = ila_id_q;
    eof_sel_d = eof_sel_q;
    unique case (bus_q)
      stp_pkg::BUS_IDLE:
      begin
        if (avs_read || avs_write)
        begin
          bus_d = stp_pkg::BUS_ACK;
          rdata_d = avs_read ? {24'h000000, rd_mux} : rdata_q;
        end
      end
      stp_pkg::BUS_ACK:
      begin
        bus_d = stp_pkg::BUS_IDLE;
        if (avs_write && avs_byteenable[0])
        begin
          case (word_idx(avs_address))
            stp_pkg::IDX_CTRL: ctrl_d = avs_writedata[1:0];
            stp_pkg::IDX_PAT: pat_d = avs_writedata[4:0];
            // odd value stored as next lower even
            stp_pkg::IDX_ID: ila_id_d = {avs_writedata[7:1], 1'b0};
            stp_pkg::IDX_EOF: eof_sel_d = avs_writedata[1:0];
            default: ctrl_d = ctrl_q;
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      bus_q <= stp_pkg::BUS_IDLE;
      rdata_q <= '0;
      ctrl_q <= stp_pkg::RST_CTRL;
      pat_q <= stp_pkg::RST_PAT;
      ila_id_q <= stp_pkg::RST_ID;
      eof_sel_q <= stp_pkg::RST_EOF;
    end
    else
    begin
      bus_q <= bus_d;
      rdata_q <= rdata_d;
      ctrl_q <= ctrl_d;
      pat_q <= pat_d;
      ila_id_q <= ila_id_d;
      eof_sel_q <= eof_sel_d;
    end
  end

  always_comb
  begin
    prbs_d = prbs_q;
    cnt_d = cnt_q;
    mf_d = mf_q;
    prev_d = prev_q;
    tx_valid_d = tx_valid_q;
    tx_data_d = tx_data_q;
    tx_k_d = tx_k_q;
    tx_raw_d = tx_raw_q;
    plt = prbs_poly(pat_q);
    pr = prbs16(prbs_q, plt[9:5], plt[4:0]);
    w = stp_pkg::WORD_LOW;
    k = 2'b00;
    raw = 1'b0;
    ok = 1'b1;
    if (!link_enable)
    begin
      prbs_d = stp_pkg::PRBS_SEED;
      cnt_d = 8'h00;
      mf_d = 2'h0;
      prev_d = 8'h00;
      tx_valid_d = 1'b0;
    end
    else if (tx_ready)
    begin
      case (pat_q)
        stp_pkg::PAT_NORMAL:
        begin
          ok = fq.pop_valid;
          w = fq.pop_data;
          if (fq.pop_valid)
            prev_d = fq.pop_data[7:0];
          // replace only a repeated last octet
          if (fq.pop_valid && !enc64 && fq.pop_data[7:0] == prev_q)
          begin
            w[7:0] = eof_char(eof_sel_q);
            k[0] = 1'b1;
          end
        end
        stp_pkg::PAT_PRBS7, stp_pkg::PAT_PRBS15, stp_pkg::PAT_PRBS23,
        stp_pkg::PAT_PRBS9, stp_pkg::PAT_PRBS31:
        begin
          w = pr[46:31];
          prbs_d = pr[30:0];
          raw = 1'b1;
        end
        stp_pkg::PAT_RAMP:
        begin
          w = {cnt_q, 8'(cnt_q + 8'h01)};
          cnt_d = 8'(cnt_q + stp_pkg::RAMP_STEP);
        end
        stp_pkg::PAT_TRANSPORT:
        begin
          w = {cnt_q, ~cnt_q};
          cnt_d = 8'(cnt_q + 8'h01);
        end
        stp_pkg::PAT_D21_5: w = {stp_pkg::CH_D21_5, stp_pkg::CH_D21_5};
        stp_pkg::PAT_K28_5:
        begin
          w = {stp_pkg::CH_K28_5, stp_pkg::CH_K28_5};
          k = 2'b11;
        end
        stp_pkg::PAT_K28_7:
        begin
          w = {stp_pkg::CH_K28_7, stp_pkg::CH_K28_7};
          k = 2'b11;
        end
        stp_pkg::PAT_ILA:
        begin
          w = {cnt_q, cnt_q};
          if (cnt_q[2:0] == 3'h0)
          begin
            w[15:8] = stp_pkg::CH_K28_0;
            k[1] = 1'b1;
            if (mf_q == stp_pkg::ILA_ID_MF)
            begin
              w[7:0] = stp_pkg::CH_K28_4;
              k[0] = 1'b1;
            end
          end
          else if (mf_q == stp_pkg::ILA_ID_MF && cnt_q[2:0] == 3'h1)
            w = {tx_id, 8'h00};
          else if (cnt_q[2:0] == stp_pkg::ILA_LAST_WORD)
          begin
            w[7:0] = stp_pkg::CH_K28_3;
            k[0] = 1'b1;
          end
          cnt_d = 8'(cnt_q + 8'h01);
          if (cnt_q[2:0] == stp_pkg::ILA_LAST_WORD)
            mf_d = 2'(mf_q + 2'h1);
        end
        stp_pkg::PAT_RPAT:
        begin
          w = rpat_word(cnt_q[2:0]);
          cnt_d = (cnt_q[2:0] == stp_pkg::RPAT_LAST) ? 8'h00 : 8'(cnt_q + 8'h01);
        end
        stp_pkg::PAT_LOW: raw = 1'b1;
        stp_pkg::PAT_HIGH:
        begin
          w = stp_pkg::WORD_HIGH;
          raw = 1'b1;
        end
        stp_pkg::PAT_CLOCK:
        begin
          w = stp_pkg::WORD_CLOCK;
          raw = 1'b1;
        end
        default: ok = 1'b0;
      endcase
      tx_valid_d = ok;
      tx_data_d = w;
      tx_k_d = k;
      tx_raw_d = raw;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      prbs_q <= stp_pkg::PRBS_SEED;
      cnt_q <= 8'h00;
      mf_q <= 2'h0;
      prev_q <= 8'h00;
      tx_valid_q <= 1'b0;
      tx_data_q <= 16'h0000;
      tx_k_q <= 2'b00;
      tx_raw_q <= 1'b0;
    end
    else
    begin
      prbs_q <= prbs_d;
      cnt_q <= cnt_d;
      mf_q <= mf_d;
      prev_q <= prev_d;
      tx_valid_q <= tx_valid_d;
      tx_data_q <= tx_data_d;
      tx_k_q <= tx_k_d;
      tx_raw_q <= tx_raw_d;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence s_adv(logic [4:0] p);
    link_enable && tx_ready && pat_q == p;
  endsequence

  sequence s_norm_pop;
    link_enable && tx_ready && pat_q == stp_pkg::PAT_NORMAL && fq.pop_valid && !enc64;
  endsequence

  a_prbs7_live: assert property (s_adv(stp_pkg::PAT_PRBS7)
    |=> tx_raw && tx_valid && tx_data != 16'h0000)
    else $error("prbs7 word wrong");
  a_prbs9_live: assert property (s_adv(stp_pkg::PAT_PRBS9)
    |=> tx_raw && tx_data != 16'h0000)
    else $error("prbs9 word wrong");
  a_ramp_step_two: assert property (s_adv(stp_pkg::PAT_RAMP) [*2]
    |=> tx_data[15:8] == 8'($past(tx_data[15:8]) + 8'h02))
    else $error("ramp step wrong");
  a_k28_5_repeat: assert property (s_adv(stp_pkg::PAT_K28_5)
    |=> tx_data == {stp_pkg::CH_K28_5, stp_pkg::CH_K28_5} && tx_k == 2'b11)
    else $error("k28.5 word wrong");
  a_static_low_hold: assert property (s_adv(stp_pkg::PAT_LOW) [*2]
    |=> tx_data == 16'h0000 && tx_raw && $past(tx_data) == 16'h0000)
    else $error("static low broken");
  a_clock_word_out: assert property (s_adv(stp_pkg::PAT_CLOCK)
    |=> tx_data == 16'h00FF && tx_raw)
    else $error("clock word wrong");
  a_ila_ident_out: assert property (s_adv(stp_pkg::PAT_ILA)
    and (mf_q == 2'h1 && cnt_q[2:0] == 3'h1)
    |=> tx_data[15:8] == 8'(ila_id_q + {7'h00, link_b}))
    else $error("alignment identifier wrong");
  a_id_even_read: assert property (bus_q == stp_pkg::BUS_ACK
    && word_idx(avs_address) == stp_pkg::IDX_ID |-> !avs_readdata[0] && !ila_id_q[0])
    else $error("identifier bit 0 set");
  a_eof_substitute: assert property (s_norm_pop and (fq.pop_data[7:0] == prev_q)
    |=> tx_k[0] && tx_data[7:0] == eof_char(eof_sel_q))
    else $error("frame end not substituted");
  a_eof_only_repeat: assert property (s_norm_pop and (fq.pop_data[7:0] != prev_q)
    |=> tx_k == 2'b00 && tx_data == $past(fq.pop_data))
    else $error("frame end inserted wrongly");
  a_eof_not_64b: assert property (tx_valid && tx_k[0] && pat_q == stp_pkg::PAT_NORMAL
    |-> !$past(enc64))
    else $error("frame end in 64b/66b");
  a_bus_answer_two: assert property (bus_q == stp_pkg::BUS_IDLE && (avs_read || avs_write)
    |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer late");
endmodule : stp_gen

//--- bench/stp_rx_model.sv
`timescale 1ns/1ps
module stp_rx_model (
  input wire logic ref_clk, // Clock
  input wire logic rst, // Synchronous reset
  input wire logic [1:0] mode, // 0 prompt, 1 every other cycle, 2 stalled
  input wire logic tx_valid, // Word offered
  output logic tx_ready, // Receiver takes the word
  output logic got // Word taken at this edge
);
  logic ready_d;
  always_comb
  begin
    ready_d = (mode == 2'h0) ? 1'b1 : ((mode == 2'h1) ? ~tx_ready : 1'b0);
  end
  always_ff @(posedge ref_clk)
  begin
    tx_ready <= rst ? 1'b0 : ready_d;
  end
  assign got = tx_ready & tx_valid;
endmodule : stp_rx_model

//--- bench/stp_gen_bench.sv
`timescale 1ns/1ps
module stp_gen_bench;
  localparam logic [11:0] A_CTRL = {stp_pkg::IDX_CTRL, 2'b00};
  localparam logic [11:0] A_PAT = {stp_pkg::IDX_PAT, 2'b00};
  localparam logic [11:0] A_ID = {stp_pkg::IDX_ID, 2'b00};
  localparam logic [11:0] A_EOF = {stp_pkg::IDX_EOF, 2'b00};
  localparam logic [4:0] FP [0:5] = '{5'h06, 5'h07, 5'h10, 5'h0A, 5'h0B, 5'h0F};
  localparam logic [31:0] FE [0:5] = '{32'h0B5B5, 32'h6BCBC, 32'h6FCFC, 32'h10000, 32'h1FFFF,
    32'h100FF};
  localparam logic [4:0] PC [0:4] = '{5'h01, 5'h02, 5'h03, 5'h0D, 5'h0E};
  localparam int TA [0:4] = '{7, 15, 23, 9, 31};
  localparam int TB [0:4] = '{6, 14, 18, 5, 28};
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] avs_address = 12'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic smp_valid = 1'b0;
  logic [15:0] smp_data = 16'h0000;
  logic smp_ready;
  logic link_b = 1'b0;
  logic tx_ready;
  logic tx_valid;
  logic [15:0] tx_data;
  logic [1:0] tx_k;
  logic tx_raw;
  logic got;
  logic [1:0] rx_mode = 2'h0;
  logic [31:0] rd;
  logic [31:0] w [0:7];
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;

  always #2 ref_clk = ~ref_clk;

  stp_gen dut (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .smp_valid(smp_valid),
    .smp_data(smp_data), .smp_ready(smp_ready), .link_b(link_b), .tx_ready(tx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_k(tx_k), .tx_raw(tx_raw));
  stp_rx_model rx (.ref_clk(ref_clk), .rst(rst), .mode(rx_mode), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .got(got));

  task close_out;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  task chk(input logic [31:0] a, input logic [31:0] e);
    n_checks++;
    if (a !== e)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, a, e);
    end
  endtask : chk

  task bus(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {24'h0, d};
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 100);
    chk({31'h0, avs_waitrequest}, 32'h0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task get(output logic [31:0] v);
    int n;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (got !== 1'b1 && n < 200);
    chk({31'h0, got}, 32'h1);
    v = {13'h0, tx_k, tx_raw, tx_data};
  endtask : get

  task push(input logic [15:0] d);
    int n;
    n = 0;
    smp_valid <= 1'b1;
    smp_data <= d;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (smp_ready !== 1'b1 && n < 200);
  endtask : push

  task set_pat(input logic [4:0] p, input logic [7:0] eof, input logic [7:0] ctrl);
    bus(1'b1, A_CTRL, 8'h00);
    bus(1'b1, A_PAT, {3'h0, p});
    bus(1'b1, A_EOF, eof);
    bus(1'b1, A_CTRL, ctrl);
  endtask : set_pat

  task t_regs;
    bus(1'b0, A_CTRL, 8'h00);
    chk(rd, 32'h0);
    bus(1'b0, A_PAT, 8'h00);
    chk(rd, 32'h0);
    bus(1'b0, A_EOF, 8'h00);
    chk(rd, 32'h0);
    bus(1'b1, 12'h900, 8'hA5);
    bus(1'b0, 12'h900, 8'h00);
    chk(rd, 32'h0);
    bus(1'b0, A_ID, 8'h00);
    chk(rd, 32'h0);
    bus(1'b1, A_ID, 8'h35);
    bus(1'b0, A_ID, 8'h00);
    chk(rd, 32'h34);
    $display("test regs done");
  endtask : t_regs

  task t_fixed;
    for (int i = 0; i < 6; i++)
    begin
      set_pat(FP[i], 8'h00, 8'h01);
      get(w[0]);
      get(w[1]);
      chk(w[0], FE[i]);
      chk(w[1], FE[i]);
    end
    // no reserved code; a disabled link stays idle
    set_pat(5'h0F, 8'h00, 8'h00);
    repeat (10) @(posedge ref_clk);
    chk({31'h0, tx_valid}, 32'h0);
    $display("test fixed done");
  endtask : t_fixed

  task t_prbs;
    logic [63:0] s;
    int bad;
    for (int i = 0; i < 5; i++)
    begin
      set_pat(PC[i], 8'h00, 8'h01);
      for (int j = 0; j < 4; j++)
        get(w[j]);
      s = {w[0][15:0], w[1][15:0], w[2][15:0], w[3][15:0]};
      bad = 0;
      for (int j = TA[i]; j < 64; j++)
        if (s[63 - j] !== (s[63 - j + TA[i]] ^ s[63 - j + TB[i]]))
          bad++;
      chk(32'(bad), 32'h0);
      chk(32'(w[0][18:16]), 32'h1);
    end
    $display("test prbs done");
  endtask : t_prbs

  task t_ramp;
    rx_mode <= 2'h0;
    set_pat(5'h04, 8'h00, 8'h01);
    get(w[0]);
    get(w[1]);
    chk(w[0], 32'h00001);
    chk(w[1], 32'h00203);
    // Receiver stalls every other cycle until the end of this test
    rx_mode <= 2'h1;
    set_pat(5'h05, 8'h00, 8'h01);
    get(w[0]);
    chk(w[0], 32'h000FF);
    set_pat(5'h09, 8'h00, 8'h01);
    for (int j = 0; j < 7; j++)
      get(w[j % 7 == 6 ? 7 : j]);
    chk(w[7], w[0]);
    rx_mode <= 2'h0;
    $display("test ramp done");
  endtask : t_ramp

  task t_ila;
    for (int i = 0; i < 2; i++)
    begin
      link_b <= i[0];
      set_pat(5'h08, 8'h00, 8'h01);
      get(w[0]);
      for (int n = 0; n < 40 && w[0] !== 32'h61C9C; n++)
        get(w[0]);
      get(w[1]);
      chk(w[0], 32'h61C9C);
      chk(w[1], i ? 32'h03500 : 32'h03400);
    end
    $display("test ila done");
  endtask : t_ila

  task t_fifo;
    rx_mode <= 2'h2;
    set_pat(5'h00, 8'h00, 8'h01);
    for (logic [7:0] b = 8'h40; b < 8'h48; b++)
      push({b, b});
    smp_valid <= 1'b0;
    @(posedge ref_clk);
    chk({31'h0, smp_ready}, 32'h0);
    rx_mode <= 2'h0;
    for (logic [7:0] b = 8'h40; b < 8'h48; b++)
    begin
      get(w[0]);
      chk(w[0], {16'h0, b, b});
    end
    chk({31'h0, smp_ready}, 32'h1);
    $display("test fifo done");
  endtask : t_fifo

  task t_eof;
    logic [7:0] ch;
    for (logic [7:0] s = 8'h00; s < 8'h04; s++)
    begin
      // select 0 first, then the generic receiver choices
      ch = stp_pkg::CH_K28_5;
      if (s == 8'h00)
        ch = stp_pkg::CH_K28_7;
      else if (s == 8'h01)
        ch = stp_pkg::CH_K28_1;
      // Lane stalled while the three words are queued, so none is missed
      rx_mode <= 2'h2;
      set_pat(5'h00, (s == 8'h03) ? 8'h00 : s, (s == 8'h03) ? 8'h03 : 8'h01);
      push({8'hA0, 8'h10 + s});
      push(16'hA155);
      push(16'hA255);
      smp_valid <= 1'b0;
      rx_mode <= 2'h0;
      get(w[0]);
      get(w[1]);
      get(w[2]);
      chk(w[0], {16'h0, 8'hA0, 8'h10 + s});
      chk(w[1], 32'h0A155);
      chk(w[2], (s == 8'h03) ? 32'h0A255 : {16'h2, 8'hA2, ch});
    end
    $display("test eof done");
  endtask : t_eof

  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      close_out();
    end
  end

  initial
  begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs();
    t_fixed();
    t_prbs();
    t_ramp();
    t_ila();
    t_fifo();
    t_eof();
    close_out();
  end
endmodule : stp_gen_bench
